// ---- selftest_pkg.sv ----
// Function
// (R1) Self-test forces transmit timing selection to reference-clock mode, overriding outside choice.
// (R2) On self-test entry each transmitter first sends the word sync sequence.
// (R3) Then transmitters repeat 256 incrementing data bytes plus three K28.5 idles.
// (R4) System enables idle insert/delete when receive word clock is not locked.
// (R5) Each receiver checks the pattern; error flag low when good, high on errors.
// (R6) Self-test enable rising edge sets every channel error flag high.
// (R7) Flag clears only after an idle then all 256 data characters without error.
// (R8) Flag goes high on any pattern mismatch or reported receiver error.
// (R9) Channel checkers run independently; no cross-channel word alignment in self-test.
// (R10) Received data and status keep flowing out as in normal operation.
// (R11) Serial loopback and rx timing select unaffected; self-test disables parallel loopback.
// (R12) Receiver enters resync on word sync reception or framing boundary change.
// (R13) Pattern runs 0 to 255 by one, then three idles, then restarts.
// (R14) Leaving self-test returns transmitters to host data and outside timing selection.
package selftest_pkg;

  localparam int          NUM_CH        = 4;
  localparam logic [8:0]  PATTERN_LEN   = 9'h100;
  localparam logic [7:0]  PATTERN_LAST  = 8'hff;
  localparam logic [1:0]  IDLE_LAST     = 2'h2;
  localparam logic [3:0]  WSYNC_LAST    = 4'hf;
  localparam logic [7:0]  K28_5_CODE    = 8'hbc;
  localparam logic [2:0]  TMODE_REFERENCE_CLOCK_IN  = 3'h0;
  localparam logic [1:0]  LB_NORMAL     = 2'h0;
  localparam logic [1:0]  LB_PARALLEL   = 2'h1;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  FLAG_OFF      = 8'h04;
  localparam logic [7:0]  INT_STAT_OFF  = 8'h08;
  localparam logic [7:0]  INT_MASK_OFF  = 8'h0c;

  // Control field positions
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_TMODE_LO = 1;
  localparam int          CTRL_LB_LO    = 4;
  localparam int          CTRL_RMODE_LO = 12;

  localparam logic [13:0] CTRL_RESET    = 14'h0000;
  localparam logic [7:0]  INT_RESET     = 8'h00;
  localparam logic [3:0]  FLAG_RESET    = 4'hf;

  typedef struct packed {
    logic       ctrl;
    logic       wsync;
    logic [7:0] data;
  } tx_char_s;

  typedef struct packed {
    logic       err;
    logic       kch;
    logic       idle;
    logic [7:0] data;
  } rx_char_s;

  typedef enum logic [3:0] {
    TX_HOST  = 4'b0001,
    TX_WSYNC = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_IDLE  = 4'b1000
  } tx_state_e;

  typedef enum logic [3:0] {
    CK_HUNT = 4'b0001,
    CK_IDLE = 4'b0010,
    CK_DATA = 4'b0100,
    CK_TAIL = 4'b1000
  } ck_state_e;

endpackage : selftest_pkg

// ---- serial_link_pattern_self_test.sv ----
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module serial_link_pattern_self_test
(
  input  wire logic                                       pclk,
  input  wire logic                                       presetn,
  input  wire logic                                       psel,
  input  wire logic                                       penable,
  input  wire logic                                       pwrite,
  input  wire logic [7:0]                                 paddr,
  input  wire logic [31:0]                                pwdata,
  output logic      [31:0]                                prdata,
  output logic                                            pready,
  output logic                                            pslverr,
  input  wire logic                                       tx_char_strobe,
  input  wire selftest_pkg::tx_char_s [selftest_pkg::NUM_CH-1:0] host_tx_char,
  output selftest_pkg::tx_char_s [selftest_pkg::NUM_CH-1:0]      line_tx_char,
  output logic      [2:0]                                 tx_timing_select,
  output logic      [2*selftest_pkg::NUM_CH-1:0]          loopback_select,
  output logic      [1:0]                                 rx_output_timing_select,
  input  wire logic [selftest_pkg::NUM_CH-1:0]            rx_char_valid,
  input  wire selftest_pkg::rx_char_s [selftest_pkg::NUM_CH-1:0] rx_char_in,
  input  wire logic [selftest_pkg::NUM_CH-1:0]            rx_wsync_seen,
  input  wire logic [selftest_pkg::NUM_CH-1:0]            rx_frame_shift,
  output selftest_pkg::rx_char_s [selftest_pkg::NUM_CH-1:0]      rx_char_out,
  output logic      [selftest_pkg::NUM_CH-1:0]            rx_char_out_valid,
  output logic      [selftest_pkg::NUM_CH-1:0]            rx_resync_enter,
  output logic      [selftest_pkg::NUM_CH-1:0]            selftest_error_flag,
  output logic                                            irq
);

  // ****************************************
  // APB decode
  // ****************************************
  logic [13:0] ctrl_q;
  logic [7:0]  int_stat_q;
  logic [7:0]  int_mask_q;
  logic [7:0]  int_set;

  wire         setup_ph   = psel & ~penable;
  wire         wr_access  = psel & penable & pwrite;
  wire         hit_ctrl   = (paddr == selftest_pkg::CTRL_OFF);
  wire         hit_flag   = (paddr == selftest_pkg::FLAG_OFF);
  wire         hit_stat   = (paddr == selftest_pkg::INT_STAT_OFF);
  wire         hit_mask   = (paddr == selftest_pkg::INT_MASK_OFF);
  wire         hit_any    = hit_ctrl | hit_flag | hit_stat | hit_mask;
  wire         wr_ctrl    = wr_access & hit_ctrl;
  wire         wr_stat    = wr_access & hit_stat;
  wire         wr_mask    = wr_access & hit_mask;
  wire [31:0]  rd_mux     = hit_ctrl ? {18'h00000, ctrl_q} :
                            hit_flag ? {28'h0000000, selftest_error_flag} :
                            hit_stat ? {24'h000000, int_stat_q} :
                            hit_mask ? {24'h000000, int_mask_q} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit_any;
      prdata  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ****************************************
  // Control, interrupt status and mask
  // ****************************************
  wire [7:0] int_stat_d = int_set | (int_stat_q & ~(wr_stat ? pwdata[7:0] : 8'h00));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= selftest_pkg::CTRL_RESET;
      int_mask_q <= selftest_pkg::INT_RESET;
      int_stat_q <= selftest_pkg::INT_RESET;
      irq        <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[13:0];
      if (wr_mask)
        int_mask_q <= pwdata[7:0];
      int_stat_q <= int_stat_d;
      irq        <= |(int_stat_d & int_mask_q);
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  logic        st_en_q;
  wire         st_en    = ctrl_q[selftest_pkg::CTRL_EN_BIT];
  wire         st_start = st_en & ~st_en_q;
  wire  [2:0]  ext_tmode = ctrl_q[selftest_pkg::CTRL_TMODE_LO +: 3];
  wire  [2:0]  eff_tmode = st_en ? selftest_pkg::TMODE_REFERENCE_CLOCK_IN : ext_tmode; // R1 R14

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_en_q                 <= 1'b0;
      tx_timing_select        <= selftest_pkg::TMODE_REFERENCE_CLOCK_IN;
      rx_output_timing_select <= 2'h0;
    end
    else
    begin
      st_en_q                 <= st_en;
      tx_timing_select        <= eff_tmode;
      rx_output_timing_select <= ctrl_q[selftest_pkg::CTRL_RMODE_LO +: 2]; // R11
    end
  end

  // ****************************************
  // Pattern generator
  // ****************************************
  selftest_pkg::tx_state_e tx_state_q;
  selftest_pkg::tx_state_e tx_state_d;
  logic [7:0]              tx_cnt_q;
  logic [7:0]              tx_cnt_d;
  selftest_pkg::tx_char_s  gen_char;

  always_comb
  begin
    tx_state_d = tx_state_q;
    tx_cnt_d   = tx_cnt_q;
    if (!st_en)
    begin
      tx_state_d = selftest_pkg::TX_HOST; // R14
      tx_cnt_d   = 8'h00;
    end
    else if (st_start)
    begin
      tx_state_d = selftest_pkg::TX_WSYNC; // R2
      tx_cnt_d   = 8'h00;
    end
    else if (tx_char_strobe)
    begin
      unique case (tx_state_q)
        selftest_pkg::TX_HOST:
        begin
          tx_state_d = selftest_pkg::TX_WSYNC;
          tx_cnt_d   = 8'h00;
        end
        selftest_pkg::TX_WSYNC:
        begin
          tx_cnt_d = tx_cnt_q + 8'h01;
          if (tx_cnt_q[3:0] == selftest_pkg::WSYNC_LAST)
          begin
            tx_state_d = selftest_pkg::TX_DATA; // R2
            tx_cnt_d   = 8'h00;
          end
        end
        selftest_pkg::TX_DATA:
        begin
          tx_cnt_d = tx_cnt_q + 8'h01; // R13
          if (tx_cnt_q == selftest_pkg::PATTERN_LAST)
            tx_state_d = selftest_pkg::TX_IDLE; // R3
        end
        selftest_pkg::TX_IDLE:
        begin
          tx_cnt_d = tx_cnt_q + 8'h01;
          if (tx_cnt_q[1:0] == selftest_pkg::IDLE_LAST)
          begin
            tx_state_d = selftest_pkg::TX_DATA; // R3 R13
            tx_cnt_d   = 8'h00;
          end
        end
      endcase
    end
  end

  always_comb
  begin
    gen_char.ctrl  = 1'b1;
    gen_char.wsync = 1'b0;
    gen_char.data  = selftest_pkg::K28_5_CODE;
    unique case (tx_state_d)
      selftest_pkg::TX_HOST:  gen_char.ctrl  = 1'b1;
      selftest_pkg::TX_WSYNC: gen_char.wsync = 1'b1; // R2
      selftest_pkg::TX_DATA:
      begin
        gen_char.ctrl = 1'b0; // R3
        gen_char.data = tx_cnt_d;
      end
      selftest_pkg::TX_IDLE:  gen_char.ctrl  = 1'b1; // R3
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_q <= selftest_pkg::TX_HOST;
      tx_cnt_q   <= 8'h00;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      tx_cnt_q   <= tx_cnt_d;
    end
  end

  // ****************************************
  // Per-channel paths and checkers
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < selftest_pkg::NUM_CH; ch++)
    begin : g_ch
      selftest_pkg::ck_state_e ck_q;
      selftest_pkg::ck_state_e ck_d;
      logic [7:0]              exp_q;
      logic [7:0]              exp_d;
      logic                    flag_d;
      selftest_pkg::rx_char_s  rc;
      wire  [1:0]              ext_lb  = ctrl_q[selftest_pkg::CTRL_LB_LO + 2*ch +: 2];
      wire                     lb_par  = (ext_lb == selftest_pkg::LB_PARALLEL);
      wire  [1:0]              eff_lb  = (st_en & lb_par) ? selftest_pkg::LB_NORMAL
                                                          : ext_lb; // R11
      wire                     tx_test = (tx_state_d != selftest_pkg::TX_HOST);

      assign rc = rx_char_in[ch];
      wire   is_idle = ~rc.err & rc.kch & rc.idle;
      wire   is_data = ~rc.err & ~rc.kch & ~rc.idle;
      wire   rx_bad  = rc.err | (~rc.kch & rc.idle); // R8
      wire   check   = st_en & ~st_start & rx_char_valid[ch]; // R9

      always_comb
      begin
        ck_d   = ck_q;
        exp_d  = exp_q;
        flag_d = selftest_error_flag[ch];
        if (st_start)
        begin
          ck_d   = selftest_pkg::CK_HUNT;
          flag_d = 1'b1; // R6
        end
        else if (check)
        begin
          unique case (ck_q)
            selftest_pkg::CK_HUNT:
              if (is_idle)
                ck_d = selftest_pkg::CK_IDLE;
            selftest_pkg::CK_IDLE:
              if (is_idle)
                ck_d = selftest_pkg::CK_IDLE;
              else if (is_data && rc.data == 8'h00)
              begin
                ck_d  = selftest_pkg::CK_DATA;
                exp_d = 8'h01;
              end
              else
              begin
                ck_d   = selftest_pkg::CK_HUNT;
                flag_d = 1'b1; // R8
              end
            selftest_pkg::CK_DATA:
              if (is_data && rc.data == exp_q && !rx_bad)
              begin
                exp_d = exp_q + 8'h01;
                if (exp_q == selftest_pkg::PATTERN_LAST)
                begin
                  ck_d   = selftest_pkg::CK_TAIL;
                  flag_d = 1'b0; // R5 R7
                end
              end
              else
              begin
                ck_d   = selftest_pkg::CK_HUNT;
                flag_d = 1'b1; // R8
              end
            selftest_pkg::CK_TAIL:
              if (is_idle)
                ck_d = selftest_pkg::CK_IDLE;
              else
              begin
                ck_d   = selftest_pkg::CK_HUNT;
                flag_d = 1'b1; // R8
              end
          endcase
        end
      end

      assign int_set[ch]                        = flag_d & ~selftest_error_flag[ch];
      assign int_set[ch + selftest_pkg::NUM_CH] = ~flag_d & selftest_error_flag[ch];

      // Checker state and error flag
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ck_q                    <= selftest_pkg::CK_HUNT;
          exp_q                   <= 8'h00;
          selftest_error_flag[ch] <= 1'b1;
        end
        else
        begin
          ck_q                    <= ck_d;
          exp_q                   <= exp_d;
          selftest_error_flag[ch] <= flag_d; // R5
        end
      end

      // Transmit character and loopback
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          line_tx_char[ch]           <= '0;
          loopback_select[2*ch +: 2] <= selftest_pkg::LB_NORMAL;
        end
        else
        begin
          line_tx_char[ch]           <= tx_test ? gen_char : host_tx_char[ch]; // R3 R14
          loopback_select[2*ch +: 2] <= eff_lb; // R11
        end
      end

      // Receive copy and resync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          rx_char_out[ch]       <= '0;
          rx_char_out_valid[ch] <= 1'b0;
          rx_resync_enter[ch]   <= 1'b0;
        end
        else
        begin
          rx_char_out[ch]       <= rx_char_in[ch]; // R10
          rx_char_out_valid[ch] <= rx_char_valid[ch]; // R10
          rx_resync_enter[ch]   <= rx_wsync_seen[ch] | rx_frame_shift[ch]; // R12
        end
      end
    end
  endgenerate

endmodule : serial_link_pattern_self_test
`default_nettype wire

// ---- slpst_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Self-test port checker
// ****************************************
module slpst_chk
(
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [7:0]                   paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic [2:0]                   tx_timing_select,
  input wire logic [7:0]                   loopback_select,
  input wire logic [3:0]                   rx_char_valid,
  input wire selftest_pkg::rx_char_s [3:0] rx_char_in,
  input wire logic [3:0]                   rx_wsync_seen,
  input wire logic [3:0]                   rx_frame_shift,
  input wire selftest_pkg::rx_char_s [3:0] rx_char_out,
  input wire logic [3:0]                   rx_char_out_valid,
  input wire logic [3:0]                   rx_resync_enter,
  input wire logic [3:0]                   selftest_error_flag
);
  logic en_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_q <= 1'b0;
    else if (psel && penable && pwrite && pready && paddr == selftest_pkg::CTRL_OFF)
      en_q <= pwdata[0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tmode;
    en_q && $past(en_q, 2) |-> tx_timing_select == selftest_pkg::TMODE_REFERENCE_CLOCK_IN;
  endproperty
  a_tmode: assert property (p_tmode) else $error("timing select not forced");
  property p_lb;
    en_q && $past(en_q, 2) |-> (loopback_select & ~(loopback_select >> 1) & 8'h55) == 8'h00;
  endproperty
  a_lb: assert property (p_lb) else $error("parallel loopback active");
  property p_rise;
    $rose(en_q) |=> selftest_error_flag == 4'hf;
  endproperty
  a_rise: assert property (p_rise) else $error("flags not set on entry");
  property p_err;
    en_q && $past(en_q, 2) && rx_char_valid[0] && rx_char_in[0].err |=> selftest_error_flag[0];
  endproperty
  a_err: assert property (p_err) else $error("flag low after bad char");
  property p_fall;
    $fell(selftest_error_flag[0])
      |-> $past(rx_char_valid[0]) && $past(rx_char_in[0].data) == 8'hff;
  endproperty
  a_fall: assert property (p_fall) else $error("flag cleared early");
  property p_resync;
    (rx_wsync_seen | rx_frame_shift) != 4'h0
      |=> rx_resync_enter == $past(rx_wsync_seen | rx_frame_shift);
  endproperty
  a_resync: assert property (p_resync) else $error("resync not entered");
  property p_copy;
    rx_char_valid != 4'h0 |=> rx_char_out == $past(rx_char_in);
  endproperty
  a_copy: assert property (p_copy) else $error("rx data not passed");
  property p_valid;
    $past(presetn) |-> rx_char_out_valid == $past(rx_char_valid);
  endproperty
  a_valid: assert property (p_valid) else $error("rx valid not passed");
  property p_slverr;
    psel && penable && pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c});
  endproperty
  a_slverr: assert property (p_slverr) else $error("bus error wrong");
endmodule : slpst_chk
bind serial_link_pattern_self_test slpst_chk u_slpst_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .tx_timing_select, .loopback_select,
  .rx_char_valid, .rx_char_in, .rx_wsync_seen, .rx_frame_shift, .rx_char_out,
  .rx_char_out_valid, .rx_resync_enter, .selftest_error_flag);
`default_nettype wire

// ---- link_partner_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Looped-back far channel
// ****************************************
module link_partner_model
(
  input  wire logic                         pclk,
  input  wire selftest_pkg::tx_char_s [3:0] line_tx_char,
  input  wire logic [3:0]                   bad_ch,
  output logic                              tx_char_strobe,
  output logic [3:0]                        rx_char_valid,
  output selftest_pkg::rx_char_s [3:0]      rx_char_in,
  output logic [3:0]                        rx_wsync_seen,
  output logic [3:0]                        rx_frame_shift
);
  logic [1:0] cnt_q = 2'h0;
  initial
  begin
    tx_char_strobe = 1'b0;
    rx_char_in = '0;
  end
  // Word clock locked to reference, so no idle insertion needed
  always @(posedge pclk)
  begin
    cnt_q <= cnt_q + 2'h1;
    tx_char_strobe <= (cnt_q == 2'h2);
    rx_char_valid <= {4{tx_char_strobe}};
    rx_wsync_seen <= 4'h0;
    rx_frame_shift <= tx_char_strobe ? bad_ch : 4'h0;
    for (int k = 0; k < 4; k++)
    begin
      if (!tx_char_strobe)
        rx_char_in[k].data <= ~rx_char_in[k].data;
      else if (line_tx_char[k].wsync)
      begin
        rx_char_in[k] <= {3'b111, line_tx_char[k].data};
        rx_wsync_seen[k] <= 1'b1;
      end
      else
        rx_char_in[k] <= {1'b0, {2{line_tx_char[k].ctrl}}, line_tx_char[k].data ^ {7'h0, bad_ch[k]}};
    end
  end
endmodule : link_partner_model
`default_nettype wire

// ---- serial_link_pattern_self_test_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Self-test bench
// ****************************************
module serial_link_pattern_self_test_tb;
  logic                         pclk = 1'b0;
  logic                         presetn = 1'b0;
  logic                         psel = 1'b0;
  logic                         penable = 1'b0;
  logic                         pwrite = 1'b0;
  logic [7:0]                   paddr = 8'h00;
  logic [31:0]                  pwdata = 32'h0;
  logic [31:0]                  prdata;
  logic                         pready, pslverr, tx_char_strobe, irq;
  selftest_pkg::tx_char_s [3:0] host_tx_char = {4{10'h03c}};
  selftest_pkg::tx_char_s [3:0] line_tx_char;
  selftest_pkg::rx_char_s [3:0] rx_char_in, rx_char_out;
  logic [2:0]                   tx_timing_select;
  logic [7:0]                   loopback_select;
  logic [1:0]                   rx_output_timing_select;
  logic [3:0]                   rx_char_valid, rx_wsync_seen, rx_frame_shift, rx_char_out_valid;
  logic [3:0]                   rx_resync_enter, selftest_error_flag;
  logic [3:0]                   bad_ch = 4'h0;
  selftest_pkg::tx_char_s       c;
  int                           err_count = 0;
  int                           n_checks = 0;
  int                           n;
  serial_link_pattern_self_test u_serial_link_pattern_self_test (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_char_strobe,
    .host_tx_char, .line_tx_char, .tx_timing_select, .loopback_select,
    .rx_output_timing_select, .rx_char_valid, .rx_char_in, .rx_wsync_seen, .rx_frame_shift,
    .rx_char_out, .rx_char_out_valid, .rx_resync_enter, .selftest_error_flag, .irq);
  link_partner_model u_link_partner_model (.pclk, .line_tx_char, .bad_ch, .tx_char_strobe,
    .rx_char_valid, .rx_char_in, .rx_wsync_seen, .rx_frame_shift);
  always #50 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic eerr);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!wr) check(prdata, exp, "read");
    check(pslverr, eerr, "slverr");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic next_char();
    @(negedge pclk iff tx_char_strobe);
    c = line_tx_char[2];
  endtask : next_char
  task automatic wait_flag(input logic [3:0] exp);
    n = 0;
    while (selftest_error_flag !== exp && n < 4000)
    begin
      @(negedge pclk);
      n++;
    end
    check(selftest_error_flag, exp, "flag");
  endtask : wait_flag
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (40000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    check({tx_timing_select, selftest_error_flag}, 7'h0f, "reset outs");
    apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'hf, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h10, 32'hffff, 32'h0, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'h255a, 32'h0, 1'b0);
    repeat (3) @(posedge pclk);
    check({tx_timing_select, loopback_select, rx_output_timing_select}, 13'h1556, "cfg");
    next_char();
    check(c, 10'h03c, "host char");
    $display("config test done");
    apb(1'b1, 8'h0c, 32'hf0, 32'h0, 1'b0);
    apb(1'b1, 8'h00, 32'h255b, 32'h0, 1'b0);
    n = 0;
    next_char();
    while (!c.wsync && n < 3)
    begin
      next_char();
      n++;
    end
    n = 0;
    while (c.wsync && n < 40)
    begin
      n++;
      next_char();
    end
    check(n, 16, "wsync count");
    check({tx_timing_select, loopback_select, rx_output_timing_select}, 13'h2, "st");
    check(selftest_error_flag, 4'hf, "entry flag");
    for (int i = 0; i < 256; i++)
    begin
      check(c, {2'b00, i[7:0]}, "pattern");
      next_char();
    end
    repeat (3)
    begin
      check(c, {2'b10, selftest_pkg::K28_5_CODE}, "idle");
      next_char();
    end
    check(c, 10'h000, "restart");
    wait_flag(4'h0);
    apb(1'b0, 8'h08, 32'h0, 32'hf0, 1'b0);
    check(irq, 1'b1, "irq pass");
    apb(1'b1, 8'h08, 32'hf0, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0, "irq clear");
    $display("pattern test done");
    @(posedge pclk);
    bad_ch <= 4'h2;
    repeat (2) next_char();
    @(posedge pclk);
    bad_ch <= 4'h0;
    wait_flag(4'h2);
    wait_flag(4'h0);
    apb(1'b0, 8'h08, 32'h0, 32'h22, 1'b0);
    check(irq, 1'b1, "irq fault");
    apb(1'b1, 8'h0c, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0, "irq masked");
    apb(1'b1, 8'h08, 32'hff, 32'h0, 1'b0);
    $display("fault test done");
    apb(1'b1, 8'h00, 32'h255a, 32'h0, 1'b0);
    repeat (3) @(posedge pclk);
    check({tx_timing_select, loopback_select, rx_output_timing_select}, 13'h1556, "exit");
    @(posedge pclk);
    bad_ch <= 4'hf;
    repeat (2) next_char();
    check(c, 10'h03c, "host back");
    @(posedge pclk);
    bad_ch <= 4'h0;
    check(selftest_error_flag, 4'h0, "flag held");
    apb(1'b1, 8'h00, 32'h255b, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    check(selftest_error_flag, 4'hf, "reentry flag");
    apb(1'b0, 8'h08, 32'h0, 32'h0f, 1'b0);
    $display("exit test done");
    report_and_stop();
  end
endmodule : serial_link_pattern_self_test_tb
`default_nettype wire
